// [bench/cpu_store_bit_ops_exec_bench.sv]
// cpu_store_bit_ops_exec_bench: self-checking bench for store_bit_exec
// assumes far_side_mem answers code reads with addr[7:0]^addr[23:16]^5A
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module cpu_store_bit_ops_exec_bench;
  typedef struct packed {
    exec_pkg::op_e op;
    logic [7:0] val;
    logic cin;
    logic [7:0] res;
    logic [3:0] flg;
  } row_s;
  // ==========
  // signals
  logic sys_clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic op_valid_in = 1'h0;
  logic page_we_in = 1'h0;
  logic [7:0] page_in = 8'h00;
  logic [4:0] view_sel_in = 5'h00;
  exec_pkg::op_s op_in = '0;
  exec_pkg::op_s w;
  logic [7:0] dmem_rdata, io_rdata, code_rdata, flags_out, page_out, view_out, fsave;
  logic prog_done, busy_out, done_out;
  logic [15:0] sp_out;
  exec_pkg::dbus_s dmem;
  exec_pkg::iobus_s io;
  exec_pkg::cbus_s code;
  int fails = 0;
  int checked = 0;
  // flags as {V,N,Z,C}
  row_s rows [0:10] = '{
    '{exec_pkg::logical_left_shift, 8'h81, 1'h0, 8'h02, 4'h9},
    '{exec_pkg::logical_left_shift, 8'h80, 1'h0, 8'h00, 4'hB},
    '{exec_pkg::logical_right_shift, 8'h01, 1'h0, 8'h00, 4'hB},
    '{exec_pkg::logical_right_shift, 8'h82, 1'h0, 8'h41, 4'h0},
    '{exec_pkg::carry_left_rotate, 8'h80, 1'h1, 8'h01, 4'h9},
    '{exec_pkg::carry_left_rotate, 8'h40, 1'h0, 8'h80, 4'hC},
    '{exec_pkg::carry_right_rotate, 8'h01, 1'h1, 8'h80, 4'h5},
    '{exec_pkg::carry_right_rotate, 8'h02, 1'h0, 8'h01, 4'h0},
    '{exec_pkg::signed_right_shift, 8'h81, 1'h0, 8'hC0, 4'h5},
    '{exec_pkg::signed_right_shift, 8'h40, 1'h0, 8'h20, 4'h0},
    '{exec_pkg::nibble_swap, 8'h3C, 1'h1, 8'hC3, 4'h1}};

  store_bit_exec dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .op_valid_in(op_valid_in),
    .op_in(op_in), .page_we_in(page_we_in), .page_in(page_in), .view_sel_in(view_sel_in),
    .dmem_rdata_in(dmem_rdata), .io_rdata_in(io_rdata), .code_rdata_in(code_rdata),
    .prog_done_in(prog_done), .busy_out(busy_out), .done_out(done_out), .dmem_out(dmem),
    .io_out(io), .code_out(code), .flags_out(flags_out), .sp_out(sp_out),
    .page_out(page_out), .view_out(view_out));
  far_side_mem far (.sys_clk_in(sys_clk_in), .dmem_in(dmem), .io_in(io), .code_in(code),
    .dmem_rdata_out(dmem_rdata), .io_rdata_out(io_rdata), .code_rdata_out(code_rdata),
    .prog_done_out(prog_done));

  initial begin
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  // ==========
  // helpers
  task automatic stop_test();
    if (fails == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  function automatic exec_pkg::op_s mk(exec_pkg::op_e o, logic [4:0] r, logic [2:0] b);
    mk = '0;
    mk.opcode = o;
    mk.rd = r;
    mk.rr = r;
    mk.bitn = b;
    mk.port = 6'h3F;
  endfunction

  // issue one op, count cycles to done, let its writes land
  task automatic do_op(exec_pkg::op_s o, int exp);
    int cyc;
    @(posedge sys_clk_in);
    op_in <= o;
    op_valid_in <= 1'h1;
    @(posedge sys_clk_in);
    op_valid_in <= 1'h0;
    for (cyc = 1; cyc < 64; cyc++) begin
      @(negedge sys_clk_in);
      if (cyc < exp) `CHK(busy_out, 1'h1)
      if (done_out === 1'h1) begin
        if (exp > 0) `CHK(cyc, exp)
        `CHK(busy_out, 1'h0)
        @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        return;
      end
      @(posedge sys_clk_in);
    end
    fails++;
    stop_test();
  endtask

  task automatic ld(logic [4:0] r, logic [7:0] v);
    far.io_q[63] = v;
    do_op(mk(exec_pkg::port_read, r, 3'h0), 1);
  endtask

  task automatic peek(logic [4:0] r, logic [7:0] e);
    @(posedge sys_clk_in);
    view_sel_in <= r;
    @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    `CHK(view_out, e)
  endtask
  // ==========
  // main sequence
  initial begin
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'h0;
    @(negedge sys_clk_in);
    `CHK({busy_out, done_out, sp_out, flags_out, page_out}, 34'h000000000)
    for (int i = 0; i < 11; i++) begin
      for (int s = 0; s < 4; s++) do_op(mk(exec_pkg::flag_bit_lower, 5'h00, s[2:0]), 1);
      if (rows[i].cin) do_op(mk(exec_pkg::flag_bit_raise, 5'h00, 3'h0), 1);
      ld(5'h10, rows[i].val);
      do_op(mk(rows[i].op, 5'h10, 3'h0), 1);
      peek(5'h10, rows[i].res);
      `CHK(flags_out[3:0], rows[i].flg)
    end
    for (int s = 0; s < 8; s++) begin
      fsave = flags_out;
      do_op(mk(exec_pkg::flag_bit_raise, 5'h00, s[2:0]), 1);
      `CHK(flags_out, fsave | (8'h01 << s))
      do_op(mk(exec_pkg::flag_bit_lower, 5'h00, s[2:0]), 1);
      `CHK(flags_out, fsave & ~(8'h01 << s))
    end
    ld(5'h10, 8'h04);
    fsave = flags_out;
    do_op(mk(exec_pkg::reg_bit_to_transfer_flag, 5'h10, 3'h2), 1);
    `CHK(flags_out, fsave | 8'h40)
    do_op(mk(exec_pkg::reg_bit_to_transfer_flag, 5'h10, 3'h3), 1);
    `CHK(flags_out, fsave & 8'hBF)
    do_op(mk(exec_pkg::reg_bit_to_transfer_flag, 5'h10, 3'h2), 1);
    ld(5'h11, 8'h00);
    fsave = flags_out;
    do_op(mk(exec_pkg::transfer_flag_to_reg_bit, 5'h11, 3'h5), 1);
    peek(5'h11, 8'h20);
    `CHK(flags_out, fsave)
    ld(5'h1C, 8'h00);
    ld(5'h1D, 8'h01);
    ld(5'h1E, 8'hFF);
    ld(5'h1F, 8'h01);
    ld(5'h10, 8'h5A);
    do_op(mk(exec_pkg::indirect_data_write_pre_dec, 5'h10, 3'h0), 2);
    `CHK(far.dmem_q[16'h00FF], 8'h5A)
    peek(5'h1C, 8'hFF);
    peek(5'h1D, 8'h00);
    ld(5'h10, 8'h6B);
    w = mk(exec_pkg::indirect_data_write_post_inc, 5'h10, 3'h0);
    w.use_z = 1'h1;
    do_op(w, 2);
    `CHK(far.dmem_q[16'h01FF], 8'h6B)
    peek(5'h1E, 8'h00);
    peek(5'h1F, 8'h02);
    ld(5'h10, 8'h7C);
    w = mk(exec_pkg::displaced_data_write, 5'h10, 3'h0);
    w.q = 6'h3F;
    do_op(w, 2);
    `CHK(far.dmem_q[16'h013E], 8'h7C)
    peek(5'h1C, 8'hFF);
    ld(5'h10, 8'h8D);
    fsave = flags_out;
    w = mk(exec_pkg::direct_data_write, 5'h10, 3'h0);
    w.k = 16'h1234;
    do_op(w, 0);
    `CHK(far.dmem_q[16'h1234], 8'h8D)
    `CHK(flags_out, fsave)
    do_op(mk(exec_pkg::stack_push, 5'h10, 3'h0), 2);
    `CHK({far.dmem_q[16'h0000], sp_out}, 24'h8DFFFF)
    do_op(mk(exec_pkg::stack_pop, 5'h12, 3'h0), 2);
    `CHK(sp_out, 16'h0000)
    peek(5'h12, 8'h8D);
    far.io_q[5] = 8'h0F;
    w = mk(exec_pkg::io_bit_raise, 5'h00, 3'h7);
    w.port = 6'h05;
    do_op(w, 2);
    `CHK(far.io_q[5], 8'h8F)
    w.opcode = exec_pkg::io_bit_lower;
    w.bitn = 3'h0;
    do_op(w, 2);
    `CHK(far.io_q[5], 8'h8E)
    w = mk(exec_pkg::port_write, 5'h10, 3'h0);
    w.port = 6'h09;
    do_op(w, 1);
    `CHK(far.io_q[9], 8'h8D)
    `CHK(flags_out, fsave)
    ld(5'h1E, 8'hFF);
    ld(5'h1F, 8'hFF);
    @(posedge sys_clk_in);
    page_we_in <= 1'h1;
    page_in <= 8'h01;
    @(posedge sys_clk_in);
    page_we_in <= 1'h0;
    do_op(mk(exec_pkg::extended_code_read_inc, 5'h14, 3'h0), 3);
    `CHK({far.code_addr_q, page_out}, 32'h01FFFF02)
    peek(5'h14, 8'hA4);
    peek(5'h1F, 8'h00);
    w = mk(exec_pkg::code_memory_read, 5'h14, 3'h0);
    w.to_r0 = 1'h1;
    do_op(w, 3);
    peek(5'h00, 8'h5A);
    do_op(mk(exec_pkg::code_memory_read_inc, 5'h15, 3'h0), 3);
    peek(5'h15, 8'h5A);
    peek(5'h1E, 8'h01);
    w.opcode = exec_pkg::extended_code_read;
    do_op(w, 3);
    `CHK(far.code_addr_q, 24'h020001)
    peek(5'h00, 8'h59);
    `CHK(flags_out, fsave)
    ld(5'h00, 8'h34);
    ld(5'h01, 8'h12);
    do_op(mk(exec_pkg::code_memory_write, 5'h00, 3'h0), 0);
    `CHK({far.code_addr_q, far.code_word_q}, 40'h0000011234)
    stop_test();
  end
endmodule

// [bench/far_side_mem.sv]
// far_side_mem: data, io and code memory on the far side of store_bit_exec
// assumes data and io answer in the strobe cycle, code memory one cycle later
`timescale 1ns/1ps
module far_side_mem (
  input wire logic sys_clk_in,
  input wire exec_pkg::dbus_s dmem_in,
  input wire exec_pkg::iobus_s io_in,
  input wire exec_pkg::cbus_s code_in,
  output logic [7:0] dmem_rdata_out,
  output logic [7:0] io_rdata_out,
  output logic [7:0] code_rdata_out,
  output logic prog_done_out
);
  // ==========
  // storage
  logic [7:0] dmem_q [0:65535];
  logic [7:0] io_q [0:63];
  logic [7:0] tog_q = 8'h00;
  logic [7:0] byte_q = 8'h00;
  logic vld_q = 1'h0;
  logic [23:0] code_addr_q = 24'h000000;
  logic [15:0] code_word_q = 16'h0000;
  logic [2:0] prog_cnt_q = 3'h0;
  initial begin
    foreach (dmem_q[i]) dmem_q[i] = 8'h00;
    foreach (io_q[i]) io_q[i] = 8'h00;
  end
  // ==========
  // read paths: idle lines show a pattern that moves every cycle
  assign dmem_rdata_out = dmem_in.re ? dmem_q[dmem_in.addr] : tog_q;
  assign io_rdata_out = io_in.re ? io_q[io_in.addr] : ~tog_q;
  assign code_rdata_out = vld_q ? byte_q : tog_q;
  assign prog_done_out = (prog_cnt_q == 3'h1);
  // ==========
  // writes, code read pipeline, slow code write
  always @(posedge sys_clk_in) begin
    tog_q <= tog_q + 8'h01;
    vld_q <= code_in.re;
    if (dmem_in.we) begin
      dmem_q[dmem_in.addr] <= dmem_in.wdata;
    end
    if (io_in.we) begin
      io_q[io_in.addr] <= io_in.wdata;
    end
    if (code_in.re || code_in.we) begin
      code_addr_q <= code_in.addr;
    end
    if (code_in.re) begin
      byte_q <= code_in.addr[7:0] ^ code_in.addr[23:16] ^ 8'h5A;
    end
    if (code_in.we) begin
      code_word_q <= code_in.wdata;
      prog_cnt_q <= 3'h5;
    end else if (prog_cnt_q != 3'h0) begin
      prog_cnt_q <= prog_cnt_q - 3'h1;
    end
  end
endmodule

// [design/exec_pkg.sv]
// exec_pkg: constants, op encoding and bus carriers for store_bit_exec
// assumes a decoder upstream that fills one op_s per instruction
package exec_pkg;
  // ==========
  // flag register bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_T = 6;

  // ==========
  // register file indices and reset values
  localparam logic [4:0] REG_R0 = 5'h00;
  localparam logic [4:0] REG_R1 = 5'h01;
  localparam logic [4:0] PTR_Y_LO = 5'h1C;
  localparam logic [4:0] PTR_Z_LO = 5'h1E;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  // ==========
  // busy cycles beyond the first
  localparam logic [1:0] RUN_TWO = 2'h1;
  localparam logic [1:0] RUN_THREE = 2'h2;

  // ==========
  // types
  typedef enum logic [4:0] {
    indirect_data_write, indirect_data_write_pre_dec, indirect_data_write_post_inc,
    displaced_data_write, direct_data_write,
    code_memory_read, code_memory_read_inc, extended_code_read, extended_code_read_inc,
    code_memory_write, port_read, port_write, stack_push, stack_pop,
    io_bit_raise, io_bit_lower, logical_left_shift, logical_right_shift,
    carry_left_rotate, carry_right_rotate, signed_right_shift, nibble_swap,
    flag_bit_raise, flag_bit_lower, reg_bit_to_transfer_flag, transfer_flag_to_reg_bit
  } op_e;

  typedef enum logic [1:0] {state_idle, state_run, state_prog_wait} state_e;
  typedef enum logic [1:0] {src_dmem, src_io, src_code} wb_src_e;

  typedef struct packed {
    op_e opcode;
    logic [4:0] rd;
    logic [4:0] rr;
    logic use_z;
    logic to_r0;
    logic [5:0] q;
    logic [15:0] k;
    logic [2:0] bitn;
    logic [5:0] port;
  } op_s;

  typedef struct packed {logic we; logic re; logic [15:0] addr; logic [7:0] wdata;} dbus_s;
  typedef struct packed {logic we; logic re; logic [5:0] addr; logic [7:0] wdata;} iobus_s;
  typedef struct packed {logic we; logic re; logic [23:0] addr; logic [15:0] wdata;} cbus_s;
endpackage

// [design/store_bit_exec.sv]
// store_bit_exec: executes stores, code reads, stack, io bit, shift, flag ops
// assumes data and io answer in the cycle of the strobe, code memory one later
`timescale 1ns/1ps
// Operation
// - pre-decrement store: decrement pointer, then write
// - post-increment store: write, then increment pointer
// - displacement store writes pointer plus q
// - direct store writes address k, flags kept
// - code read from Z, optional Z increment
// - extended read uses page above Z
// - extended increment carries into page
// - push writes stack, adjusts pointer, two cycles
// - pop adjusts pointer, loads register, two cycles
// - io bit raise forces one bit high
// - io bit lower forces one bit low
// - left shift, zero into bit 0
// - right shift, zero into bit 7
// - rotate left through carry
// - rotate right through carry
// - arithmetic right shift keeps sign bit
// - nibble swap, flags untouched
// - register bit copied into T
// - T copied into register bit
// - single flag set or clear
module store_bit_exec (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic op_valid_in,
  input wire exec_pkg::op_s op_in,
  input wire logic page_we_in,
  input wire logic [7:0] page_in,
  input wire logic [4:0] view_sel_in,
  input wire logic [7:0] dmem_rdata_in,
  input wire logic [7:0] io_rdata_in,
  input wire logic [7:0] code_rdata_in,
  input wire logic prog_done_in,
  output logic busy_out,
  output logic done_out,
  output exec_pkg::dbus_s dmem_out,
  output exec_pkg::iobus_s io_out,
  output exec_pkg::cbus_s code_out,
  output logic [7:0] flags_out,
  output logic [15:0] sp_out,
  output logic [7:0] page_out,
  output logic [7:0] view_out
);
  // ==========
  // state
  logic [7:0] rf_q [32];
  exec_pkg::op_s op_q;
  exec_pkg::state_e state_q;
  exec_pkg::wb_src_e wb_src_q;
  exec_pkg::dbus_s dmem_q;
  exec_pkg::iobus_s io_q;
  exec_pkg::cbus_s code_q;
  logic [1:0] cnt_q;
  logic [7:0] flags_q;
  logic [15:0] sp_q;
  logic [7:0] page_q;
  logic [7:0] view_q;
  logic busy_q;
  logic done_q;
  logic wb_q;
  logic [4:0] wb_idx_q;

  // ==========
  // operand fetch with bypass of the pending load
  wire [7:0] wb_data = (wb_src_q == exec_pkg::src_io) ? io_rdata_in :
                       (wb_src_q == exec_pkg::src_code) ? code_rdata_in : dmem_rdata_in;

  function automatic logic [7:0] fwd(input logic [4:0] idx);
    fwd = (wb_q && wb_idx_q == idx) ? wb_data : rf_q[idx];
  endfunction

  wire exec_pkg::op_e opc = op_in.opcode;
  wire take = op_valid_in && (state_q == exec_pkg::state_idle);
  wire [4:0] ptr_lo = op_in.use_z ? exec_pkg::PTR_Z_LO : exec_pkg::PTR_Y_LO;
  wire [7:0] rd_val = fwd(op_in.rd);
  wire [7:0] rr_val = fwd(op_in.rr);
  wire [15:0] ptr_val = {fwd(ptr_lo + 5'h01), fwd(ptr_lo)};
  wire [15:0] z_val = {fwd(exec_pkg::PTR_Z_LO + 5'h01), fwd(exec_pkg::PTR_Z_LO)};
  wire [23:0] far_val = {page_q, z_val};
  wire [23:0] far_inc = far_val + 24'h000001;
  wire [4:0] dest_idx = op_in.to_r0 ? exec_pkg::REG_R0 : op_in.rd;
  wire [7:0] mask_in = 8'h01 << op_in.bitn;
  wire [7:0] mask_q = 8'h01 << op_q.bitn;

  // ==========
  // op classes
  wire is_store = opc inside {exec_pkg::indirect_data_write,
    exec_pkg::indirect_data_write_pre_dec, exec_pkg::indirect_data_write_post_inc,
    exec_pkg::displaced_data_write, exec_pkg::direct_data_write};
  wire is_code = opc inside {exec_pkg::code_memory_read, exec_pkg::code_memory_read_inc,
    exec_pkg::extended_code_read, exec_pkg::extended_code_read_inc};
  wire is_far = opc inside {exec_pkg::extended_code_read, exec_pkg::extended_code_read_inc};
  wire is_rmw = opc inside {exec_pkg::io_bit_raise, exec_pkg::io_bit_lower};
  wire is_two = is_store || is_rmw || opc inside {exec_pkg::stack_push, exec_pkg::stack_pop};
  wire is_shift = opc inside {exec_pkg::logical_left_shift, exec_pkg::logical_right_shift,
    exec_pkg::carry_left_rotate, exec_pkg::carry_right_rotate, exec_pkg::signed_right_shift};

  // ==========
  // data write address
  wire [15:0] wr_addr =
    (opc == exec_pkg::indirect_data_write_pre_dec) ? ptr_val - 16'h0001 :
    (opc == exec_pkg::displaced_data_write) ? ptr_val + {10'h000, op_in.q} :
    (opc == exec_pkg::direct_data_write) ? op_in.k :
    (opc == exec_pkg::stack_push) ? sp_q : ptr_val;

  // ==========
  // pointer write-back
  wire ptr_we = take && opc inside {exec_pkg::indirect_data_write_pre_dec,
    exec_pkg::indirect_data_write_post_inc, exec_pkg::code_memory_read_inc,
    exec_pkg::extended_code_read_inc};
  wire [4:0] ptr_w_idx = is_code ? exec_pkg::PTR_Z_LO : ptr_lo;
  wire [15:0] ptr_new =
    (opc == exec_pkg::indirect_data_write_pre_dec) ? ptr_val - 16'h0001 :
    (opc == exec_pkg::indirect_data_write_post_inc) ? ptr_val + 16'h0001 :
    (opc == exec_pkg::extended_code_read_inc) ? far_inc[15:0] : z_val + 16'h0001;

  // ==========
  // shifter
  logic [7:0] sh_res;
  logic sh_c;
  always_comb begin
    sh_res = rd_val;
    sh_c = flags_q[exec_pkg::FLAG_C];
    case (opc)
      exec_pkg::logical_left_shift: begin
        sh_res = {rd_val[6:0], 1'b0};
        sh_c = rd_val[7];
      end
      exec_pkg::logical_right_shift: begin
        sh_res = {1'b0, rd_val[7:1]};
        sh_c = rd_val[0];
      end
      exec_pkg::carry_left_rotate: begin
        sh_res = {rd_val[6:0], flags_q[exec_pkg::FLAG_C]};
        sh_c = rd_val[7];
      end
      exec_pkg::carry_right_rotate: begin
        sh_res = {flags_q[exec_pkg::FLAG_C], rd_val[7:1]};
        sh_c = rd_val[0];
      end
      exec_pkg::signed_right_shift: begin
        sh_res = {rd_val[7], rd_val[7:1]};
        sh_c = rd_val[0];
      end
      default: begin
      end
    endcase
  end

  // ==========
  // single-cycle register result
  wire res_we = take && (is_shift || opc inside {exec_pkg::nibble_swap,
    exec_pkg::transfer_flag_to_reg_bit});
  wire [7:0] res_data = (opc == exec_pkg::nibble_swap) ? {rd_val[3:0], rd_val[7:4]} :
    (opc == exec_pkg::transfer_flag_to_reg_bit) ?
      (flags_q[exec_pkg::FLAG_T] ? (rd_val | mask_in) : (rd_val & ~mask_in)) : sh_res;

  // ==========
  // register file; op result written last, it sees bypassed operands
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < 32; i++) begin
        rf_q[i] <= 8'h00;
      end
      view_q <= 8'h00;
    end else begin
      if (wb_q) begin
        rf_q[wb_idx_q] <= wb_data;
      end
      if (ptr_we) begin
        rf_q[ptr_w_idx] <= ptr_new[7:0];
        rf_q[ptr_w_idx + 5'h01] <= ptr_new[15:8];
      end
      if (res_we) begin
        rf_q[op_in.rd] <= res_data;
      end
      view_q <= rf_q[view_sel_in];
    end
  end

  // ==========
  // flags, stack pointer, page register
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      flags_q <= exec_pkg::FLAGS_RESET;
      sp_q <= exec_pkg::SP_RESET;
      page_q <= exec_pkg::PAGE_RESET;
    end else begin
      if (page_we_in) begin
        page_q <= page_in;
      end
      if (take && is_shift) begin
        flags_q[exec_pkg::FLAG_Z] <= (sh_res == 8'h00);
        flags_q[exec_pkg::FLAG_C] <= sh_c;
        flags_q[exec_pkg::FLAG_N] <= sh_res[7];
        flags_q[exec_pkg::FLAG_V] <= sh_res[7] ^ sh_c;
      end
      if (take && opc == exec_pkg::flag_bit_raise) begin
        flags_q[op_in.bitn] <= 1'b1;
      end
      if (take && opc == exec_pkg::flag_bit_lower) begin
        flags_q[op_in.bitn] <= 1'b0;
      end
      if (take && opc == exec_pkg::reg_bit_to_transfer_flag) begin
        flags_q[exec_pkg::FLAG_T] <= rr_val[op_in.bitn];
      end
      if (take && opc == exec_pkg::stack_push) begin
        sp_q <= sp_q - 16'h0001;
      end
      if (take && opc == exec_pkg::stack_pop) begin
        sp_q <= sp_q + 16'h0001;
      end
      if (take && opc == exec_pkg::extended_code_read_inc) begin
        page_q <= far_inc[23:16];
      end
    end
  end

  // ==========
  // sequencer and bus strobes
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q <= exec_pkg::state_idle;
      op_q <= '0;
      cnt_q <= 2'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      wb_q <= 1'b0;
      wb_idx_q <= 5'h00;
      wb_src_q <= exec_pkg::src_dmem;
      dmem_q <= '0;
      io_q <= '0;
      code_q <= '0;
    end else begin
      dmem_q.we <= 1'b0;
      dmem_q.re <= 1'b0;
      io_q.we <= 1'b0;
      io_q.re <= 1'b0;
      code_q.we <= 1'b0;
      code_q.re <= 1'b0;
      done_q <= 1'b0;
      wb_q <= 1'b0;
      case (state_q)
        exec_pkg::state_idle: begin
          if (take) begin
            op_q <= op_in;
            busy_q <= is_two || is_code || opc == exec_pkg::code_memory_write;
            done_q <= !(is_two || is_code || opc == exec_pkg::code_memory_write);
            cnt_q <= is_code ? exec_pkg::RUN_THREE : exec_pkg::RUN_TWO;
            if (is_two || is_code) begin
              state_q <= exec_pkg::state_run;
            end
            if (is_store || opc == exec_pkg::stack_push) begin
              dmem_q.we <= 1'b1;
              dmem_q.addr <= wr_addr;
              dmem_q.wdata <= rr_val;
            end
            if (opc == exec_pkg::stack_pop) begin
              dmem_q.re <= 1'b1;
              dmem_q.addr <= sp_q + 16'h0001;
              wb_q <= 1'b1;
              wb_idx_q <= op_in.rd;
              wb_src_q <= exec_pkg::src_dmem;
            end
            if (is_code) begin
              code_q.re <= 1'b1;
              code_q.addr <= is_far ? far_val : {8'h00, z_val};
              wb_idx_q <= dest_idx;
              wb_src_q <= exec_pkg::src_code;
            end
            if (opc == exec_pkg::port_write) begin
              io_q.we <= 1'b1;
              io_q.addr <= op_in.port;
              io_q.wdata <= rr_val;
            end
            if (opc == exec_pkg::port_read || is_rmw) begin
              io_q.re <= 1'b1;
              io_q.addr <= op_in.port;
              wb_q <= !is_rmw;
              wb_idx_q <= op_in.rd;
              wb_src_q <= exec_pkg::src_io;
            end
            if (opc == exec_pkg::code_memory_write) begin
              code_q.we <= 1'b1;
              code_q.addr <= {8'h00, z_val};
              code_q.wdata <= {fwd(exec_pkg::REG_R1), fwd(exec_pkg::REG_R0)};
              state_q <= exec_pkg::state_prog_wait;
            end
          end
        end
        exec_pkg::state_run: begin
          cnt_q <= cnt_q - 2'h1;
          // code memory answers one cycle after the strobe
          if (cnt_q == exec_pkg::RUN_THREE) begin
            wb_q <= 1'b1;
          end
          if (cnt_q == exec_pkg::RUN_TWO) begin
            state_q <= exec_pkg::state_idle;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            if (op_q.opcode inside {exec_pkg::io_bit_raise, exec_pkg::io_bit_lower}) begin
              io_q.we <= 1'b1;
              io_q.wdata <= (op_q.opcode == exec_pkg::io_bit_raise) ?
                (io_rdata_in | mask_q) : (io_rdata_in & ~mask_q);
            end
          end
        end
        exec_pkg::state_prog_wait: begin
          if (prog_done_in) begin
            state_q <= exec_pkg::state_idle;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
        end
        default: begin
          state_q <= exec_pkg::state_idle;
        end
      endcase
    end
  end

  // ==========
  // outputs
  assign busy_out = busy_q;
  assign done_out = done_q;
  assign dmem_out = dmem_q;
  assign io_out = io_q;
  assign code_out = code_q;
  assign flags_out = flags_q;
  assign sp_out = sp_q;
  assign page_out = page_q;
  assign view_out = view_q;

  // ==========
  // checks
  a_pre_dec_addr:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && opc == exec_pkg::indirect_data_write_pre_dec |=>
    dmem_q.we && dmem_q.addr == $past(ptr_val) - 16'h0001 ##1 done_q)
    else $error("pre-decrement store address wrong");
  a_post_inc_addr:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && opc == exec_pkg::indirect_data_write_post_inc |=>
    dmem_q.addr == $past(ptr_val) && busy_q ##1 done_q && !busy_q)
    else $error("post-increment store wrong");
  a_disp_addr:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && opc == exec_pkg::displaced_data_write |=>
    dmem_q.we && dmem_q.addr == $past(ptr_val) + {10'h000, $past(op_in.q)})
    else $error("displacement address wrong");
  a_direct_flags:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && opc == exec_pkg::direct_data_write |=>
    dmem_q.addr == $past(op_in.k) && flags_q == $past(flags_q))
    else $error("direct store wrong");
  a_code_read_len:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && is_code |=> code_q.re && busy_q ##1 busy_q ##1 done_q && !busy_q)
    else $error("code read length wrong");
  a_push_stack:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && opc == exec_pkg::stack_push |=>
    dmem_q.addr == $past(sp_q) && sp_q == $past(sp_q) - 16'h0001)
    else $error("push wrong");
  a_io_raise_bit:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && opc == exec_pkg::io_bit_raise |=> io_q.re ##1
    io_q.we && io_q.wdata == ($past(io_rdata_in) | mask_q))
    else $error("io bit raise wrong");
  a_shift_carry:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && opc == exec_pkg::logical_left_shift |=>
    flags_q[exec_pkg::FLAG_C] == $past(rd_val[7]) && done_q)
    else $error("left shift carry wrong");
  a_swap_flags:
  assert property (@(posedge sys_clk_in) disable iff (rst_in)
    take && opc == exec_pkg::nibble_swap |=> flags_q == $past(flags_q) && done_q)
    else $error("swap changed flags");
endmodule
